// ---- logic/bsctp_defines.vh ----
/*
 Constants for the boundary-scan test port: instruction codes, register sizes,
 identity word field positions and synchroniser timing.
 Assumes it is included by its bare name from the design file.
*/
`ifndef BSCTP_DEFINES_VH
`define BSCTP_DEFINES_VH

// ==========================================================================
// Instruction codes
// ==========================================================================
`define BSCTP_INS_WIDTH        4
`define BSCTP_INS_EXTEST       4'h0
`define BSCTP_INS_SAMPLE       4'h1
`define BSCTP_INS_IDCODE       4'h2
`define BSCTP_INS_CLAMP        4'h3
`define BSCTP_INS_HIGHZ        4'h4
`define BSCTP_INS_BYPASS       4'hF
`define BSCTP_INS_CAPTURE      4'h1

// ==========================================================================
// Identity word layout
// ==========================================================================
`define BSCTP_ID_WIDTH         32
`define BSCTP_ID_VER_MSB       31
`define BSCTP_ID_VER_LSB       28
`define BSCTP_ID_PART_MSB      27
`define BSCTP_ID_PART_LSB      12
`define BSCTP_ID_MFR_MSB       11
`define BSCTP_ID_MFR_LSB       1
`define BSCTP_ID_MARKER        1'h1

// ==========================================================================
// Timing
// ==========================================================================
`define BSCTP_CLK_PERIOD_NS    8
`define BSCTP_TCK_PERIOD_NS    100
`define BSCTP_PIN_IDLE         4'hB

`endif

// ---- logic/bsctp_test_port.v ----
/*
 Boundary-scan test access logic: tap state machine, 4-bit instruction shift
 register, pass-through cell, identity word and an edge cell chain.
 Assumes the test clock, mode select, test data in and test reset come from
 an outside controller and are sampled here on clk; edges are detected after
 two flip-flops, so the test clock must be much slower than clk.
*/
// Summary of operation
// - The instruction register is 4 bits and code 0000 puts the edge chain on the path and drives cell contents onto the outputs.
// - Code 1111 puts the one-bit pass-through cell between test data in and out.
// - Code 0010 loads the 32-bit identity word at capture and shifts it out.
// - Code 0100 uses the pass-through cell and releases every device output but test data out to high impedance.
// - Code 0011 drives cell contents onto the outputs while the pass-through cell is the path.
// - Code 0001 puts the edge chain on the path and captures the live input and output values.
// - Under code 0001 values shift into the cells without disturbing normal operation.
// - Identity bits 31:28 hold the version field.
// - Identity bits 27:12 hold the 16-bit part number.
// - Identity bits 11:1 hold the 11-bit manufacturer code.
// - Identity bit 0 always reads 1.
// - Edge cells cover all device outputs but test data out and all inputs but the test pins.
`timescale 1ns/1ns
`include "bsctp_defines.vh"

module bsctp_test_port #(
    parameter NUM_IN   = 8,
    parameter NUM_OUT  = 8,
    parameter [3:0]  VERSION_CODE = 4'h1,      // Arbitrary value.
    parameter [15:0] PART_CODE    = 16'h0A5A,  // Arbitrary value.
    parameter [10:0] MFR_CODE     = 11'h155    // Arbitrary value.
) (
    input  wire               clk,
    input  wire               rst_n,
    input  wire               testClk,
    input  wire               modeSelect,
    input  wire               testDataIn,
    input  wire               testReset_n,
    input  wire [NUM_IN-1:0]  coreIn,
    input  wire [NUM_OUT-1:0] coreOut,
    input  wire [NUM_OUT-1:0] coreOutEn_n,
    output reg                testDataOut,
    output reg                testDataOutEn_n,
    output reg  [NUM_IN-1:0]  inToCore,
    output reg  [NUM_OUT-1:0] padOut,
    output reg  [NUM_OUT-1:0] padOutEn_n
);
    // ======================================================================
    // Chain length and tap states
    // ======================================================================
    localparam CHAIN = NUM_IN + 2 * NUM_OUT;
    localparam [15:0] S_RESET = 16'h0001, S_IDLE = 16'h0002, S_SELDR = 16'h0004,
                      S_CAPDR = 16'h0008, S_SHDR = 16'h0010, S_EX1DR = 16'h0020,
                      S_PADR  = 16'h0040, S_EX2DR = 16'h0080, S_UPDR = 16'h0100,
                      S_SELIR = 16'h0200, S_CAPIR = 16'h0400, S_SHIR = 16'h0800,
                      S_EX1IR = 16'h1000, S_PAIR  = 16'h2000, S_EX2IR = 16'h4000,
                      S_UPIR  = 16'h8000;

    // ======================================================================
    // Reset release and pin synchronisers
    // ======================================================================
    reg [1:0] rstSync_q;
    wire      rstInt_n = rstSync_q[1];
    reg [3:0] pinMeta_q;
    reg [3:0] pinSync_q;
    reg       tckLast_q;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rstSync_q <= 2'h0;
        else
            rstSync_q <= {rstSync_q[0], 1'h1};
    end
    always @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            // Pins start at their idle levels so that release shows no false test clock edge.
            pinMeta_q <= `BSCTP_PIN_IDLE;
            pinSync_q <= `BSCTP_PIN_IDLE;
            tckLast_q <= 1'h1;
        end
        else
        begin
            pinMeta_q <= {testReset_n, testDataIn, modeSelect, testClk};
            pinSync_q <= pinMeta_q;
            tckLast_q <= pinSync_q[0];
        end
    end
    wire tckRise = pinSync_q[0] & ~tckLast_q;
    wire tckFall = ~pinSync_q[0] & tckLast_q;
    wire tmsS    = pinSync_q[1];
    wire tdiS    = pinSync_q[2];
    wire trstS_n = pinSync_q[3];

    // ======================================================================
    // Tap state machine
    // ======================================================================
    reg [15:0] state_q;
    reg [15:0] state_d;
    always @*
    begin
        case (state_q)
            S_RESET: state_d = tmsS ? S_RESET : S_IDLE;
            S_IDLE:  state_d = tmsS ? S_SELDR : S_IDLE;
            S_SELDR: state_d = tmsS ? S_SELIR : S_CAPDR;
            S_CAPDR: state_d = tmsS ? S_EX1DR : S_SHDR;
            S_SHDR:  state_d = tmsS ? S_EX1DR : S_SHDR;
            S_EX1DR: state_d = tmsS ? S_UPDR : S_PADR;
            S_PADR:  state_d = tmsS ? S_EX2DR : S_PADR;
            S_EX2DR: state_d = tmsS ? S_UPDR : S_SHDR;
            S_UPDR:  state_d = tmsS ? S_SELDR : S_IDLE;
            S_SELIR: state_d = tmsS ? S_RESET : S_CAPIR;
            S_CAPIR: state_d = tmsS ? S_EX1IR : S_SHIR;
            S_SHIR:  state_d = tmsS ? S_EX1IR : S_SHIR;
            S_EX1IR: state_d = tmsS ? S_UPIR : S_PAIR;
            S_PAIR:  state_d = tmsS ? S_EX2IR : S_PAIR;
            S_EX2IR: state_d = tmsS ? S_UPIR : S_SHIR;
            S_UPIR:  state_d = tmsS ? S_SELDR : S_IDLE;
            default: state_d = S_RESET;
        endcase
    end

    // ======================================================================
    // Instruction decode
    // ======================================================================
    reg [3:0] insShift_q;
    reg [3:0] ins_q;
    // Reserved codes fall to the pass-through path so a stray code stays harmless.
    wire selChain = (ins_q == `BSCTP_INS_EXTEST) || (ins_q == `BSCTP_INS_SAMPLE);
    wire selId    = (ins_q == `BSCTP_INS_IDCODE);
    wire drive    = (ins_q == `BSCTP_INS_EXTEST) || (ins_q == `BSCTP_INS_CLAMP);
    wire floatAll = (ins_q == `BSCTP_INS_HIGHZ);
    wire [31:0] idWord = {VERSION_CODE, PART_CODE, MFR_CODE, `BSCTP_ID_MARKER};

    // ======================================================================
    // Data registers, shifted on test clock rise
    // ======================================================================
    reg              passCell_q;
    reg [31:0]       idShift_q;
    reg [CHAIN-1:0]  cellShift_q;
    reg [CHAIN-1:0]  cellHold_q;
    always @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            state_q     <= S_RESET;
            insShift_q  <= 4'h0;
            ins_q       <= `BSCTP_INS_IDCODE;
            passCell_q  <= 1'h0;
            idShift_q   <= 32'h0;
            cellShift_q <= {CHAIN{1'b0}};
            cellHold_q  <= {CHAIN{1'b0}};
        end
        else if (!trstS_n)
        begin
            state_q <= S_RESET;
            ins_q   <= `BSCTP_INS_IDCODE;
        end
        else if (tckRise)
        begin
            state_q <= state_d;
            if (state_q == S_RESET)
                ins_q <= `BSCTP_INS_IDCODE;
            if (state_q == S_CAPIR)
                insShift_q <= `BSCTP_INS_CAPTURE;
            if (state_q == S_SHIR)
                insShift_q <= {tdiS, insShift_q[3:1]};
            if (state_q == S_UPIR)
                ins_q <= insShift_q;
            if (state_q == S_CAPDR)
            begin
                passCell_q  <= 1'h0;
                idShift_q   <= idWord;
                cellShift_q <= {coreOutEn_n, coreOut, coreIn};
            end
            if (state_q == S_SHDR)
            begin
                passCell_q  <= tdiS;
                idShift_q   <= {tdiS, idShift_q[31:1]};
                if (selChain)
                    cellShift_q <= {tdiS, cellShift_q[CHAIN-1:1]};
            end
            if (state_q == S_UPDR && selChain)
                cellHold_q <= cellShift_q;
        end
    end

    // ======================================================================
    // Test data out on falling test clock, pad multiplexers
    // ======================================================================
    reg serialBit;
    always @*
    begin
        if (state_q == S_SHIR)
            serialBit = insShift_q[0];
        else if (selChain)
            serialBit = cellShift_q[0];
        else if (selId)
            serialBit = idShift_q[0];
        else
            serialBit = passCell_q;
    end
    always @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            testDataOut     <= 1'h0;
            testDataOutEn_n <= 1'h1;
            inToCore        <= {NUM_IN{1'b0}};
            padOut          <= {NUM_OUT{1'b0}};
            padOutEn_n      <= {NUM_OUT{1'b1}};
        end
        else
        begin
            if (tckFall)
            begin
                testDataOut     <= serialBit;
                testDataOutEn_n <= ~((state_q == S_SHIR) || (state_q == S_SHDR));
            end
            // Sample/preload leaves the core path untouched.
            inToCore   <= (ins_q == `BSCTP_INS_EXTEST) ? cellHold_q[NUM_IN-1:0] : coreIn;
            padOut     <= drive ? cellHold_q[NUM_IN+NUM_OUT-1:NUM_IN] : coreOut;
            padOutEn_n <= floatAll ? {NUM_OUT{1'b1}} :
                          drive ? cellHold_q[CHAIN-1:NUM_IN+NUM_OUT] : coreOutEn_n;
        end
    end
endmodule // bsctp_test_port

// ---- verif/bsctp_monitor.sv ----
/* Checker of the test port pins.
   Assumes test clock phases of four clk or longer. */
`timescale 1ns/1ns
module bsctp_monitor #(
    parameter NUM_IN  = 8,
    parameter NUM_OUT = 8
) (
    input wire               clk,
    input wire               rst_n,
    input wire               testClk,
    input wire               testDataOut,
    input wire               testDataOutEn_n,
    input wire [NUM_IN-1:0]  coreIn,
    input wire [NUM_OUT-1:0] coreOut,
    input wire [NUM_OUT-1:0] coreOutEn_n,
    input wire [NUM_IN-1:0]  inToCore,
    input wire [NUM_OUT-1:0] padOut,
    input wire [NUM_OUT-1:0] padOutEn_n
);
    // ==========
    // Edge windows
    // The pins pass two synchroniser flops, so a window of eight clk is allowed.
    reg  [7:0] hist_q;
    reg  [2:0] age_q;
    wire       fallWin = |(hist_q[7:1] & ~hist_q[6:0]);
    wire       riseWin = |(~hist_q[7:1] & hist_q[6:0]);
    wire       live    = age_q == 3'h7;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hist_q <= 8'hFF;
            age_q  <= 3'h0;
        end
        else
        begin
            hist_q <= {hist_q[6:0], testClk};
            age_q  <= live ? age_q : age_q + 3'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_tdo; live && $changed(testDataOut) |-> fallWin; endproperty
    a_tdo: assert property (p_tdo) else $error("tdo moved off a fall");
    property p_ten; live && $changed(testDataOutEn_n) |-> fallWin; endproperty
    a_ten: assert property (p_ten) else $error("tdo enable moved off a fall");
    property p_tdoHold; $rose(testClk) |-> ##2 $stable(testDataOut) [*3]; endproperty
    a_tdoHold: assert property (p_tdoHold) else $error("tdo moved in high phase");
    property p_tenHold; $rose(testClk) |-> ##2 $stable(testDataOutEn_n) [*3]; endproperty
    a_tenHold: assert property (p_tenHold) else $error("enable moved in high phase");
    property p_shift; $fell(testDataOutEn_n) |-> ##[1:400] $rose(testDataOutEn_n); endproperty
    a_shift: assert property (p_shift) else $error("shift never ended");
    property p_pad;
        live && $changed(padOut) |-> $past(coreOut) != $past(coreOut, 2) || riseWin;
    endproperty
    a_pad: assert property (p_pad) else $error("pad data moved alone");
    property p_padEn;
        live && $changed(padOutEn_n) |-> $past(coreOutEn_n) != $past(coreOutEn_n, 2) || riseWin;
    endproperty
    a_padEn: assert property (p_padEn) else $error("pad enable moved alone");
    property p_core;
        live && $changed(inToCore) |-> $past(coreIn) != $past(coreIn, 2) || riseWin;
    endproperty
    a_core: assert property (p_core) else $error("core input moved alone");
endmodule // bsctp_monitor
bind bsctp_test_port bsctp_monitor #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) i_bsctp_monitor (
    .clk, .rst_n, .testClk, .testDataOut, .testDataOutEn_n, .coreIn, .coreOut,
    .coreOutEn_n, .inToCore, .padOut, .padOutEn_n);

// ---- verif/bsctp_tap_driver.sv ----
/* Behavioural test controller on the tap pins.
   Assumes its tasks are entered at a falling clk edge. */
`timescale 1ns/1ns
module bsctp_tap_driver (
    input  wire clk,
    input  wire testDataOut,
    output reg  testClk,
    output reg  modeSelect,
    output reg  testDataIn,
    output reg  testReset_n
);
    initial
    begin
        testClk     = 1'b1;
        modeSelect  = 1'b1;
        testDataIn  = 1'b0;
        testReset_n = 1'b1;
    end
    // ==========
    // Pin sequencing
    // One period of 64 ns; tdo is read late, as it only settles some clk after the fall.
    task tick(input ms, input di, output dOut);
    begin
        testClk    = 1'b0;
        modeSelect = ms;
        testDataIn = di;
        repeat (4) @(negedge clk);
        testClk = 1'b1;
        repeat (4) @(negedge clk);
        dOut = testDataOut;
    end
    endtask
    // Idle to shift, n bits least significant first, back to Idle.
    // Idle data is inverted each period so no stale level is left on the line.
    task scan(input insPath, input integer n, input [63:0] din, output [63:0] dout);
        integer i;
        reg     b;
    begin
        dout = 64'h0;
        tick(1'b0, ~testDataIn, b);
        tick(1'b1, ~testDataIn, b);
        if (insPath)
            tick(1'b1, ~testDataIn, b);
        tick(1'b0, ~testDataIn, b);
        tick(1'b0, ~testDataIn, b);
        for (i = 0; i < n; i = i + 1)
            tick(i == n - 1, din[i], dout[i]);
        tick(1'b1, ~testDataIn, b);
        tick(1'b0, ~testDataIn, b);
    end
    endtask
    task treset;
    begin
        testReset_n = 1'b0;
        repeat (8) @(negedge clk);
        testReset_n = 1'b1;
        repeat (8) @(negedge clk);
    end
    endtask
endmodule // bsctp_tap_driver

// ---- verif/testbench.sv ----
/* Self-checking bench of the test port.
   Assumes the tap driver model stands on the test pins. */
`timescale 1ns/1ns
module testbench;
    localparam [31:0] ID_EXP = {4'h1, 16'h0A5A, 11'h155, 1'b1};
    localparam [11:0] LOOP_CODES = 12'h34F;
    localparam [95:0] LOOP_EXP = {32'h005AA5C3, 32'h00FF5AC3, 32'h000F5AC3};
    reg         clk;
    reg         rst_n;
    reg  [7:0]  coreIn;
    reg  [7:0]  coreOut;
    reg  [7:0]  coreOutEn_n;
    wire        testClk;
    wire        modeSelect;
    wire        testDataIn;
    wire        testReset_n;
    wire        testDataOut;
    wire        testDataOutEn_n;
    wire [7:0]  inToCore;
    wire [7:0]  padOut;
    wire [7:0]  padOutEn_n;
    reg  [63:0] rd;
    integer     k;
    integer     err_count;
    integer     samples_checked;
    bsctp_test_port #(.VERSION_CODE(4'h1), .PART_CODE(16'h0A5A), .MFR_CODE(11'h155))
        i_bsctp_test_port (.clk, .rst_n, .testClk, .modeSelect, .testDataIn, .testReset_n,
        .coreIn, .coreOut, .coreOutEn_n, .testDataOut, .testDataOutEn_n, .inToCore,
        .padOut, .padOutEn_n);
    bsctp_tap_driver i_bsctp_tap_driver (.clk, .testDataOut, .testClk, .modeSelect,
        .testDataIn, .testReset_n);
    always #4 clk = ~clk;
    task chk(input [31:0] got, input [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task loadIns(input [3:0] code);
        i_bsctp_tap_driver.scan(1'b1, 4, {60'h0, code}, rd);
    endtask
    task dr(input integer n, input [63:0] din);
        i_bsctp_tap_driver.scan(1'b0, n, din, rd);
    endtask
    task complete_run;
    begin
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    // About fifteen scans of under 3 us each; the limit leaves wide margin.
    initial
    begin
        #200000;
        err_count = err_count + 1;
        complete_run;
    end
    initial
    begin
        clk             = 1'b0;
        rst_n           = 1'b0;
        coreIn          = 8'h3C;
        coreOut         = 8'hA5;
        coreOutEn_n     = 8'h0F;
        err_count       = 0;
        samples_checked = 0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        dr(32, 64'h0);
        chk(rd[31:0], ID_EXP);
        loadIns(4'h2);
        chk({28'h0, rd[3:0]}, 32'h1);
        dr(32, 64'h0);
        chk(rd[31:0], ID_EXP);
        loadIns(4'h1);
        dr(24, 64'hC39669);
        chk({8'h0, rd[23:0]}, 32'h0FA53C);
        coreOut = 8'h5A;
        coreIn  = 8'hC3;
        repeat (3) @(negedge clk);
        chk({8'h0, padOutEn_n, padOut, inToCore}, 32'h0F5AC3);
        loadIns(4'h0);
        chk({8'h0, padOutEn_n, padOut, inToCore}, 32'hC39669);
        dr(24, 64'h5AA55A);
        chk({8'h0, padOutEn_n, padOut, inToCore}, 32'h5AA55A);
        for (k = 0; k < 3; k = k + 1)
        begin
            loadIns(LOOP_CODES[8 - 4 * k +: 4]);
            dr(8, 64'hA5);
            chk({24'h0, rd[7:0]}, 32'h4A);
            chk({8'h0, padOutEn_n, padOut, inToCore}, LOOP_EXP[64 - 32 * k +: 32]);
        end
        i_bsctp_tap_driver.treset;
        dr(32, 64'h0);
        chk(rd[31:0], ID_EXP);
        chk({31'h0, testDataOutEn_n}, 32'h1);
        complete_run;
    end
endmodule // testbench
